// [bench/tb_touch_panel_i2c_target.sv]
// self-checking bench for host and touch target joined back to back
`timescale 1ns/1ps
`default_nettype none
module tb_touch_panel_i2c_target;
  import tp_i2c_pkg::*;
  `define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %0t %s", $time, m); end end
  logic i_clk;
  logic i_rstn = 1'b0, addr_sel = 1'b0, cmd_valid = 1'b0, cmd_read = 1'b0, int_req = 1'b0;
  logic [15:0] cmd_reg = 16'h0000;
  logic [7:0] cmd_len = 8'h00, wr_data = 8'h5a;
  logic cmd_ready, wr_take, rd_valid, done, nack, irq, t_wr_valid, t_rd_take, t_addr_sel;
  logic [7:0] rd_data, t_wr_data, t_rd_data;
  logic [15:0] t_wr_addr, t_rd_addr;
  logic [7:0] regs [256];
  logic [7:0] sent[$], rd_q[$], wr_d[$];
  logic [15:0] wr_a[$];
  int seed = 90, n_mismatch = 0, checked = 0, n_take = 0;
  ////////////////////////////////////////////////////////////////////////
  tp_i2c_if i_tp_i2c_if();
  tp_i2c_host #(.RST_CYC(8), .INT_CYC(8), .QTR(4)) i_tp_i2c_host (
    .i_clk(i_clk), .i_rstn(i_rstn), .bus(i_tp_i2c_if), .i_addr_sel(addr_sel),
    .i_cmd_valid(cmd_valid), .i_cmd_read(cmd_read), .i_cmd_reg(cmd_reg), .i_cmd_len(cmd_len),
    .o_cmd_ready(cmd_ready), .i_wr_data(wr_data), .o_wr_take(wr_take), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_done(done), .o_nack(nack), .o_irq(irq));
  tp_i2c_target i_tp_i2c_target (
    .i_clk(i_clk), .i_rstn(i_rstn), .bus(i_tp_i2c_if), .o_wr_valid(t_wr_valid),
    .o_wr_addr(t_wr_addr), .o_wr_data(t_wr_data), .o_rd_addr(t_rd_addr), .o_rd_take(t_rd_take),
    .i_rd_data(t_rd_data), .i_int_req(int_req), .o_addr_sel(t_addr_sel));
  tp_i2c_assertions i_tp_i2c_assertions (
    .i_clk(i_clk), .i_rstn(i_rstn), .scl(i_tp_i2c_if.scl), .sda(i_tp_i2c_if.sda),
    .sda_h_oe(i_tp_i2c_if.sda_h_oe), .sda_d_oe(i_tp_i2c_if.sda_d_oe),
    .dev_rst_n(i_tp_i2c_if.dev_rst_n));
  assign t_rd_data = regs[t_rd_addr[7:0]];
  ////////////////////////////////////////////////////////////////////////
  // register store behind the target, and host-side data source
  always @(posedge i_clk) begin
    if (t_wr_valid) begin
      regs[t_wr_addr[7:0]] <= t_wr_data;
      wr_a.push_back(t_wr_addr);
      wr_d.push_back(t_wr_data);
    end
    if (rd_valid) rd_q.push_back(rd_data);
    if (t_rd_take) n_take++;
    if (wr_take) begin
      sent.push_back(wr_data);
      wr_data <= 8'($random(seed));
    end
  end
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_addr(input logic [15:0] b, input int k);
    return b + k[15:0];
  endfunction
  task automatic wait_ready;
    int w;
    w = 0;
    while (cmd_ready !== 1'b1 && w < 5000) begin
      @(posedge i_clk);
      w++;
    end
  endtask
  task automatic do_cmd(input logic rd, input logic [15:0] ra, input int n);
    int w;
    wait_ready();
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_reg <= ra;
    cmd_len <= n[7:0];
    @(posedge i_clk);
    cmd_valid <= 1'b0;
    w = 0;
    while (done !== 1'b1 && w < 20000) begin
      @(posedge i_clk);
      w++;
    end
    @(posedge i_clk);
    `CHK(w < 20000, 1'b1, "command hang")
  endtask
  // write n bytes from ra, read them back in one sequential read
  task automatic wr_rd(input logic [15:0] ra, input int n);
    sent.delete();
    wr_a.delete();
    wr_d.delete();
    rd_q.delete();
    n_take = 0;
    do_cmd(1'b0, ra, n);
    `CHK(nack, 1'b0, "write not acked")
    `CHK(wr_a.size(), n, "write byte count")
    `CHK(t_rd_addr, exp_addr(ra, n), "pointer after write")
    for (int k = 0; k < n; k++) begin
      `CHK(wr_a[k], exp_addr(ra, k), "write address")
      `CHK(wr_d[k], sent[k], "write data")
    end
    do_cmd(1'b1, ra, n);
    `CHK(nack, 1'b0, "read not acked")
    `CHK(rd_q.size(), n, "read byte count")
    `CHK(n_take, n, "target byte loads")
    for (int k = 0; k < n && k < rd_q.size(); k++) begin
      `CHK(rd_q[k], sent[k], "read data")
    end
    `CHK(t_rd_addr, exp_addr(ra, n - 1), "pointer after final nack")
  endtask
  task automatic results;
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    wait_ready();
    `CHK(t_addr_sel, 1'b0, "address pair after low interrupt")
    wr_rd(16'hffff, 2);
    wr_rd(16'h0000, 1);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      wr_rd(r[15:0], int'(r[18:16]) + 1);
    end
    int_req <= 1'b1;
    repeat (12) @(posedge i_clk);
    `CHK(irq, 1'b1, "interrupt not seen")
    int_req <= 1'b0;
    repeat (12) @(posedge i_clk);
    `CHK(irq, 1'b0, "interrupt not cleared")
    i_rstn <= 1'b0;
    addr_sel <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    wait_ready();
    `CHK(t_addr_sel, 1'b1, "address pair after high interrupt")
    wr_rd(16'h8140, 8);
    results();
  end
  initial begin
    #(90000 * 40);
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire

// [bench/tp_i2c_assertions.sv]
// bus-level checks on the link between host and touch target
`timescale 1ns/1ps
`default_nettype none
module tp_i2c_assertions (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // link wires and drives
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_h_oe,
  input wire logic sda_d_oe,
  input wire logic dev_rst_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////
  logic scl_ff, sda_ff, frame_ff, any_ff, nxt_frame, nxt_any, start_ev, stop_ev;
  logic [3:0] bits_ff, nxt_bits;
  always_comb begin
    start_ev = scl && scl_ff && sda_ff && !sda;
    stop_ev = scl && scl_ff && !sda_ff && sda;
    nxt_bits = bits_ff;
    nxt_any = any_ff;
    nxt_frame = frame_ff;
    if (scl && !scl_ff) begin
      nxt_bits = (bits_ff == 4'h8) ? 4'h0 : bits_ff + 4'h1;
      nxt_any = 1'b1;
    end
    if (start_ev || stop_ev) begin
      nxt_bits = 4'h0;
      nxt_any = 1'b0;
      nxt_frame = start_ev;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      bits_ff <= 4'h0;
      any_ff <= 1'b0;
      frame_ff <= 1'b0;
    end else begin
      scl_ff <= scl;
      sda_ff <= sda;
      bits_ff <= nxt_bits;
      any_ff <= nxt_any;
      frame_ff <= nxt_frame;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_sda_hold_high: assert property (scl && scl_ff |-> $stable(sda_d_oe))
    else $error("target moved data while clock high");
  a_dev_edge_low: assert property ($changed(sda_d_oe) |-> !scl ##1 !scl)
    else $error("target data change not inside clock low");
  a_start_by_host: assert property (start_ev |-> sda_h_oe && !sda_d_oe)
    else $error("start not made by host");
  a_stop_by_host: assert property (stop_ev |-> $past(sda_h_oe) && !$past(sda_d_oe))
    else $error("stop not made by host");
  a_unit_nine_clk: assert property ((start_ev && any_ff) || stop_ev |-> bits_ff == 4'h1)
    else $error("frame not whole nine-clock units");
  a_ack_on_ninth: assert property ($rose(sda_d_oe) && bits_ff == 4'h8 |-> ##[1:300] ($rose(scl) && sda_d_oe))
    else $error("ack not held at ninth clock");
  a_idle_quiet: assert property (!frame_ff |-> !sda_d_oe)
    else $error("target drives data outside a frame");
  a_rst_quiet: assert property (!dev_rst_n [*4] |-> !sda_d_oe)
    else $error("target drives data while held in reset");
endmodule
`default_nettype wire

// [logic/tp_i2c_host.sv]
// host controller end of the touch panel serial link
`timescale 1ns/1ps
`default_nettype none
module tp_i2c_host
  import tp_i2c_pkg::*;
#(
  parameter int RST_CYC = RST_HOLD_CYC,
  parameter int INT_CYC = INT_HOLD_CYC,
  parameter int QTR = QTR_CYC
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // serial link
  tp_i2c_if.host bus,
  // command
  input wire logic i_addr_sel,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_read,
  input wire logic [REG_AW-1:0] i_cmd_reg,
  input wire logic [7:0] i_cmd_len,
  output logic o_cmd_ready,
  // data
  input wire logic [BYTE_W-1:0] i_wr_data,
  output logic o_wr_take,
  output logic [BYTE_W-1:0] o_rd_data,
  output logic o_rd_valid,
  // status
  output logic o_done,
  output logic o_nack,
  output logic o_irq
);
  typedef enum {H_INIT, H_IDLE, H_START, H_BYTE, H_STOP} host_state_type;
  typedef enum {K_AW, K_HI, K_LO, K_WD, K_AR, K_RD} kind_type;

  //////////////////////////////////////////////////////////////////////
  // input synchronisers: {int_n, sda}
  logic [1:0] s1_ff;
  logic [1:0] s2_ff;
  logic [1:0] s3_ff;
  logic [1:0] flt_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s1_ff <= 2'h3;
      s2_ff <= 2'h3;
      s3_ff <= 2'h3;
      flt_ff <= 2'h3;
    end else begin
      s1_ff <= {bus.int_n, bus.sda};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < 2; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          flt_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // sequencer
  host_state_type st_ff, nxt_st;
  kind_type kind_ff, nxt_kind;
  logic [CNT_W-1:0] tick_ff, nxt_tick;
  logic [1:0] ph_ff, nxt_ph;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] sh_ff, nxt_sh;
  logic [7:0] rx_ff, nxt_rx;
  logic [7:0] cnt_ff, nxt_cnt;
  logic rd_ff, nxt_rd;
  logic [REG_AW-1:0] reg_ff, nxt_reg;
  logic scl_oe_ff, nxt_scl_oe;
  logic sda_oe_ff, nxt_sda_oe;
  logic ack_ff, nxt_ack;
  logic rst_ff, nxt_rst;
  logic int_oe_ff, nxt_int_oe;
  logic sel_ff, nxt_sel;
  logic wr_take_ff, nxt_wr_take;
  logic rd_valid_ff, nxt_rd_valid;
  logic [7:0] rd_data_ff, nxt_rd_data;
  logic done_ff, nxt_done;
  logic nack_ff, nxt_nack;
  logic step;
  logic lvl_a;
  logic lvl_b;
  logic [6:0] addr7;

  assign addr7 = sel_ff ? ADDR_PAIR_B : ADDR_PAIR_A;
  assign step = (tick_ff == CNT_W'(QTR - 1));

  always_comb begin
    // sda level for phases 1-2 (a) and phase 3 (b)
    lvl_a = 1'b1;
    lvl_b = 1'b1;
    if (st_ff == H_START) begin
      lvl_b = 1'b0; // [R01]
    end else if (st_ff == H_STOP) begin
      lvl_a = 1'b0; // [R07]
    end else if (bit_ff == 4'h8) begin
      // last read byte gets nack [R12]
      lvl_a = ~(kind_ff == K_RD && cnt_ff != 8'h01);
      lvl_b = lvl_a;
    end else if (kind_ff != K_RD) begin
      lvl_a = sh_ff[7];
      lvl_b = sh_ff[7];
    end
  end

  always_comb begin
    nxt_st = st_ff; nxt_kind = kind_ff; nxt_tick = tick_ff;
    nxt_ph = ph_ff; nxt_bit = bit_ff; nxt_sh = sh_ff; nxt_rx = rx_ff;
    nxt_cnt = cnt_ff; nxt_rd = rd_ff; nxt_reg = reg_ff;
    nxt_scl_oe = scl_oe_ff; nxt_sda_oe = sda_oe_ff; nxt_ack = ack_ff;
    nxt_rst = rst_ff; nxt_int_oe = int_oe_ff; nxt_sel = sel_ff;
    nxt_rd_data = rd_data_ff; nxt_nack = nack_ff;
    nxt_wr_take = 1'b0; nxt_rd_valid = 1'b0; nxt_done = 1'b0;
    case (st_ff)
      H_INIT: begin
        // hold device reset, then interrupt line, to pick address [R13]
        nxt_tick = tick_ff + 1'b1;
        nxt_int_oe = ~sel_ff;
        if (!rst_ff) begin
          nxt_sel = i_addr_sel;
        end
        if (!rst_ff && tick_ff == CNT_W'(RST_CYC - 1)) begin
          nxt_rst = 1'b1;
          nxt_tick = '0;
        end else if (rst_ff && tick_ff == CNT_W'(INT_CYC - 1)) begin
          nxt_int_oe = 1'b0;
          nxt_tick = '0;
          nxt_st = H_IDLE;
        end
      end
      H_IDLE: begin
        nxt_tick = '0;
        if (i_cmd_valid) begin
          nxt_st = H_START; // [R01]
          nxt_ph = 2'h0;
          nxt_kind = K_AW;
          nxt_rd = i_cmd_read;
          nxt_reg = i_cmd_reg;
          nxt_cnt = (i_cmd_len == 8'h00) ? 8'h01 : i_cmd_len;
          nxt_nack = 1'b0;
          nxt_scl_oe = 1'b1;
        end
      end
      default: begin
        nxt_tick = step ? '0 : tick_ff + 1'b1;
        if (step && ph_ff != 2'h3) begin
          // clock low phases carry sda changes [R06]
          nxt_ph = ph_ff + 2'h1;
          nxt_scl_oe = (ph_ff == 2'h0);
          nxt_sda_oe = (ph_ff == 2'h2) ? ~lvl_b : ~lvl_a;
          if (st_ff == H_BYTE && ph_ff == 2'h2) begin
            if (bit_ff == 4'h8) begin
              nxt_ack = flt_ff[0];
            end else begin
              nxt_rx = {rx_ff[6:0], flt_ff[0]};
            end
          end
        end else if (step) begin
          nxt_ph = 2'h0;
          nxt_scl_oe = 1'b1;
          nxt_bit = 4'h0;
          nxt_st = H_BYTE;
          if (st_ff == H_STOP) begin
            nxt_st = H_IDLE;
            nxt_scl_oe = 1'b0;
            nxt_done = 1'b1;
          end else if (st_ff == H_START) begin
            // eight-bit address word [R02] [R08] [R10]
            nxt_sh = {addr7, kind_ff == K_AR};
          end else if (bit_ff != 4'h8) begin
            nxt_st = H_BYTE;
            nxt_bit = bit_ff + 4'h1;
            nxt_sh = {sh_ff[6:0], 1'b1};
          end else if (kind_ff == K_RD) begin
            nxt_rd_valid = 1'b1;
            nxt_rd_data = rx_ff;
            nxt_cnt = cnt_ff - 8'h01;
            if (cnt_ff == 8'h01) begin
              nxt_st = H_STOP; // [R12]
            end
          end else if (ack_ff) begin
            nxt_nack = 1'b1;
            nxt_st = H_STOP;
          end else begin
            case (kind_ff)
              K_AW: begin
                nxt_kind = K_HI; // [R08]
                nxt_sh = reg_ff[15:8];
              end
              K_HI: begin
                nxt_kind = K_LO;
                nxt_sh = reg_ff[7:0];
              end
              K_AR: begin
                nxt_kind = K_RD;
              end
              default: begin
                if (kind_ff == K_WD) begin
                  nxt_cnt = cnt_ff - 8'h01;
                end
                if (rd_ff) begin
                  nxt_kind = K_AR; // repeated start [R10]
                  nxt_st = H_START;
                end else if (kind_ff == K_WD && cnt_ff == 8'h01) begin
                  nxt_st = H_STOP; // [R08]
                end else begin
                  nxt_kind = K_WD;
                  nxt_sh = i_wr_data;
                  nxt_wr_take = 1'b1;
                end
              end
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_ff <= H_INIT; kind_ff <= K_AW; tick_ff <= '0; ph_ff <= 2'h0;
      bit_ff <= 4'h0; sh_ff <= 8'h00; rx_ff <= 8'h00; cnt_ff <= 8'h00;
      rd_ff <= 1'b0; reg_ff <= 16'h0000; scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0; ack_ff <= 1'b0; rst_ff <= 1'b0;
      int_oe_ff <= 1'b0; sel_ff <= 1'b0; wr_take_ff <= 1'b0;
      rd_valid_ff <= 1'b0; rd_data_ff <= 8'h00; done_ff <= 1'b0;
      nack_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st; kind_ff <= nxt_kind; tick_ff <= nxt_tick;
      ph_ff <= nxt_ph; bit_ff <= nxt_bit; sh_ff <= nxt_sh; rx_ff <= nxt_rx;
      cnt_ff <= nxt_cnt; rd_ff <= nxt_rd; reg_ff <= nxt_reg;
      scl_oe_ff <= nxt_scl_oe; sda_oe_ff <= nxt_sda_oe; ack_ff <= nxt_ack;
      rst_ff <= nxt_rst; int_oe_ff <= nxt_int_oe;
      sel_ff <= nxt_sel;
      wr_take_ff <= nxt_wr_take; rd_valid_ff <= nxt_rd_valid;
      rd_data_ff <= nxt_rd_data; done_ff <= nxt_done; nack_ff <= nxt_nack;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  logic low_ff;
  logic ready_ff;
  logic irq_ff;

  always_ff @(posedge i_clk) begin
    low_ff <= 1'b0;
    if (!i_rstn) begin
      ready_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      ready_ff <= (nxt_st == H_IDLE);
      irq_ff <= ~flt_ff[1] & ~int_oe_ff;
    end
  end

  assign bus.scl_h_o = low_ff;
  assign bus.scl_h_oe = scl_oe_ff;
  assign bus.sda_h_o = low_ff;
  assign bus.sda_h_oe = sda_oe_ff;
  assign bus.int_h_o = low_ff;
  assign bus.int_h_oe = int_oe_ff;
  assign bus.dev_rst_n = rst_ff;
  assign o_cmd_ready = ready_ff;
  assign o_wr_take = wr_take_ff;
  assign o_rd_data = rd_data_ff;
  assign o_rd_valid = rd_valid_ff;
  assign o_done = done_ff;
  assign o_nack = nack_ff;
  assign o_irq = irq_ff;
endmodule
`default_nettype wire

// [logic/tp_i2c_if.sv]
// open-drain wires between host controller and touch target
`timescale 1ns/1ps
`default_nettype none
interface tp_i2c_if;
  logic scl_h_o;
  logic scl_h_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic int_h_o;
  logic int_h_oe;
  logic int_d_o;
  logic int_d_oe;
  logic dev_rst_n;
  logic scl;
  logic sda;
  logic int_n;
  // wired-and with pull-ups
  assign scl = ~(scl_h_oe & ~scl_h_o);
  assign sda = ~(sda_h_oe & ~sda_h_o) & ~(sda_d_oe & ~sda_d_o);
  assign int_n = ~(int_h_oe & ~int_h_o) & ~(int_d_oe & ~int_d_o);
  modport dev (
    input scl, sda, int_n, dev_rst_n,
    output sda_d_o, sda_d_oe, int_d_o, int_d_oe
  );
  modport host (
    input sda, int_n,
    output scl_h_o, scl_h_oe, sda_h_o, sda_h_oe, int_h_o, int_h_oe, dev_rst_n
  );
endinterface
`default_nettype wire

// [logic/tp_i2c_pkg.sv]
// shared constants for the touch panel serial link
package tp_i2c_pkg;
  // target addresses, 7-bit form of the 8-bit address words
  localparam logic [6:0] ADDR_PAIR_A = 7'h5D;
  localparam logic [6:0] ADDR_PAIR_B = 7'h14;
  localparam int BYTE_W = 8;
  localparam int REG_AW = 16;
  localparam int BITS_PER_UNIT = 9;
  // timing
  localparam int CLK_NS = 40;
  localparam int BIT_NS = 2500;
  localparam int QTR_CYC = (BIT_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
  localparam int RST_HOLD_NS = 10000;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int INT_HOLD_NS = 10000;
  localparam int INT_HOLD_CYC = (INT_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 16;
endpackage

// [logic/tp_i2c_target.sv]
// touch controller serial target end
// Summary of operation
// R01: host alone opens transfers with start
// R02: address words move as eight bits
// R03: acknowledge matching address on ninth clock
// R04: unmatched address: no ack, idle till start
// R05: nine clocks per unit, target acks received
// R06: data changes only while clock low
// R07: host ends transfer with stop
// R08: write: address, 16-bit register, data, stop
// R09: pointer advances after each written byte
// R10: read: set pointer, repeated start, read
// R11: sequential read active by default
// R12: host acks all but last, then stop
// R13: reset and interrupt pick address pair
// R14: interrupt output; clock up to 400k
// R15: read returns pointer byte, advance on ack
`timescale 1ns/1ps
`default_nettype none
module tp_i2c_target
  import tp_i2c_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // serial link
  tp_i2c_if.dev bus,
  // register write port
  output logic o_wr_valid,
  output logic [REG_AW-1:0] o_wr_addr,
  output logic [BYTE_W-1:0] o_wr_data,
  // register read port
  output logic [REG_AW-1:0] o_rd_addr,
  output logic o_rd_take,
  input wire logic [BYTE_W-1:0] i_rd_data,
  // interrupt and address selection
  input wire logic i_int_req,
  output logic o_addr_sel
);
  typedef enum {D_IDLE, D_RX, D_ACK, D_TX, D_TXACK} dev_state_type;

  //////////////////////////////////////////////////////////////////////
  // input synchronisers: {dev_rst_n, int_n, sda, scl}
  logic [3:0] s1_ff;
  logic [3:0] s2_ff;
  logic [3:0] s3_ff;
  logic [3:0] flt_ff;
  logic [3:0] prev_ff;
  logic [3:0] nxt_flt;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      nxt_flt[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : flt_ff[i];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s1_ff <= 4'hF;
      s2_ff <= 4'hF;
      s3_ff <= 4'hF;
      flt_ff <= 4'hF;
      prev_ff <= 4'hF;
    end else begin
      s1_ff <= {bus.dev_rst_n, bus.int_n, bus.sda, bus.scl};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      flt_ff <= nxt_flt;
      prev_ff <= flt_ff;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic dev_on;

  // bus conditions seen with clock high [R01] [R07]
  assign scl_rise = flt_ff[0] & ~prev_ff[0];
  assign scl_fall = ~flt_ff[0] & prev_ff[0];
  assign start_det = flt_ff[0] & prev_ff[0] & ~flt_ff[1] & prev_ff[1];
  assign stop_det = flt_ff[0] & prev_ff[0] & flt_ff[1] & ~prev_ff[1];
  assign dev_on = flt_ff[3];

  //////////////////////////////////////////////////////////////////////
  // protocol engine
  dev_state_type st_ff;
  dev_state_type nxt_st;
  logic [7:0] sh_ff;
  logic [7:0] nxt_sh;
  logic [3:0] bit_ff;
  logic [3:0] nxt_bit;
  logic [1:0] idx_ff;
  logic [1:0] nxt_idx;
  logic rd_ff;
  logic nxt_rd;
  logic [REG_AW-1:0] ptr_ff;
  logic [REG_AW-1:0] nxt_ptr;
  logic sda_oe_ff;
  logic nxt_sda_oe;
  logic wr_valid_ff;
  logic nxt_wr_valid;
  logic [REG_AW-1:0] wr_addr_ff;
  logic [REG_AW-1:0] nxt_wr_addr;
  logic [BYTE_W-1:0] wr_data_ff;
  logic [BYTE_W-1:0] nxt_wr_data;
  logic rd_take_ff;
  logic nxt_rd_take;
  logic int_oe_ff;
  logic nxt_int_oe;
  logic sel_ff;
  logic nxt_sel;
  logic [6:0] my_addr;

  assign my_addr = sel_ff ? ADDR_PAIR_B : ADDR_PAIR_A;

  always_comb begin
    nxt_st = st_ff;
    nxt_sh = sh_ff;
    nxt_bit = bit_ff;
    nxt_idx = idx_ff;
    nxt_rd = rd_ff;
    nxt_ptr = ptr_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_wr_valid = 1'b0;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    nxt_rd_take = 1'b0;
    nxt_sel = sel_ff;
    // active-low interrupt driven only while running [R14]
    nxt_int_oe = dev_on & i_int_req;
    if (!dev_on) begin
      nxt_st = D_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (!prev_ff[3]) begin
      // interrupt level at reset release picks the pair [R13]
      nxt_sel = flt_ff[2];
    end else if (start_det) begin
      // start or repeated start always restarts addressing [R04]
      nxt_st = D_RX;
      nxt_bit = 4'h0;
      nxt_idx = 2'h0;
      nxt_sda_oe = 1'b0;
    end else if (stop_det) begin
      nxt_st = D_IDLE;
      nxt_sda_oe = 1'b0;
    end else begin
      case (st_ff)
        D_RX: begin
          if (scl_rise) begin
            // sample only while clock high [R06] [R02]
            nxt_sh = {sh_ff[6:0], flt_ff[1]};
            nxt_bit = bit_ff + 4'h1;
          end else if (scl_fall && bit_ff == 4'h8) begin
            // ninth clock: acknowledge [R05]
            nxt_st = D_ACK;
            nxt_sda_oe = 1'b1;
            nxt_idx = (idx_ff == 2'h3) ? idx_ff : idx_ff + 2'h1;
            if (idx_ff == 2'h0) begin
              if (sh_ff[7:1] == my_addr) begin
                nxt_rd = sh_ff[0]; // [R03]
              end else begin
                nxt_st = D_IDLE; // [R04]
                nxt_sda_oe = 1'b0;
              end
            end else if (idx_ff == 2'h1) begin
              nxt_ptr = {sh_ff, ptr_ff[7:0]};
            end else if (idx_ff == 2'h2) begin
              nxt_ptr = {ptr_ff[15:8], sh_ff};
            end else begin
              nxt_wr_valid = 1'b1;
              nxt_wr_addr = ptr_ff;
              nxt_wr_data = sh_ff;
              nxt_ptr = ptr_ff + 16'h0001; // [R09]
            end
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            nxt_bit = 4'h0;
            if (rd_ff) begin
              // load the byte at the pointer [R15] [R11]
              nxt_st = D_TX;
              nxt_sh = i_rd_data;
              nxt_rd_take = 1'b1;
              nxt_sda_oe = ~i_rd_data[7]; // [R06]
            end else begin
              nxt_st = D_RX;
              nxt_sda_oe = 1'b0;
            end
          end
        end
        D_TX: begin
          if (scl_fall) begin
            if (bit_ff == 4'h7) begin
              nxt_st = D_TXACK;
              nxt_sda_oe = 1'b0;
            end else begin
              nxt_bit = bit_ff + 4'h1;
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_sda_oe = ~sh_ff[6]; // [R06]
            end
          end
        end
        D_TXACK: begin
          if (scl_rise) begin
            if (!flt_ff[1]) begin
              // host ack: next byte follows [R15] [R11]
              nxt_ptr = ptr_ff + 16'h0001;
              nxt_st = D_ACK;
            end else begin
              nxt_st = D_IDLE;
            end
          end
        end
        default: begin
          nxt_st = D_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_ff <= D_IDLE;
      sh_ff <= 8'h00;
      bit_ff <= 4'h0;
      idx_ff <= 2'h0;
      rd_ff <= 1'b0;
      ptr_ff <= 16'h0000;
      sda_oe_ff <= 1'b0;
      wr_valid_ff <= 1'b0;
      wr_addr_ff <= 16'h0000;
      wr_data_ff <= 8'h00;
      rd_take_ff <= 1'b0;
      int_oe_ff <= 1'b0;
      sel_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      sh_ff <= nxt_sh;
      bit_ff <= nxt_bit;
      idx_ff <= nxt_idx;
      rd_ff <= nxt_rd;
      ptr_ff <= nxt_ptr;
      sda_oe_ff <= nxt_sda_oe;
      wr_valid_ff <= nxt_wr_valid;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
      rd_take_ff <= nxt_rd_take;
      int_oe_ff <= nxt_int_oe;
      sel_ff <= nxt_sel;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  logic low_ff;

  always_ff @(posedge i_clk) begin
    low_ff <= 1'b0;
  end

  assign bus.sda_d_o = low_ff;
  assign bus.sda_d_oe = sda_oe_ff;
  assign bus.int_d_o = low_ff;
  assign bus.int_d_oe = int_oe_ff;
  assign o_wr_valid = wr_valid_ff;
  assign o_wr_addr = wr_addr_ff;
  assign o_wr_data = wr_data_ff;
  assign o_rd_addr = ptr_ff;
  assign o_rd_take = rd_take_ff;
  assign o_addr_sel = sel_ff;
endmodule
`default_nettype wire
